// >>> hdl/core_interrupt_control_regs.sv
/*
 Interrupt control register block: main and secondary control registers, flags,
 edge detection, priority routing, port pull-up control.
 Assumes source pins are asynchronous; the request on the link is a one-cycle pulse.
*/
// Design decisions made here: the link interface to the registers and the routing of flags to the two request lines.
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module core_interrupt_control_regs
    import irq_ctrl_pkg::*;
#(
    parameter int PINS = 4
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    irq_ctrl_if.device link,
    input wire logic priority_mode_enable,
    input wire logic periph_irq_pending,
    input wire logic periph_irq_high_pending,
    input wire logic periph_irq_low_pending,
    input wire logic timer_overflow_pulse,
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    input wire logic ext_irq_two_pin,
    input wire logic [PINS-1:0] portb_pins,
    input wire logic [PINS-1:0] portb_is_input,
    input wire logic [PINS-1:0] per_pin_change_enable,
    input wire logic [PINS-1:0] per_pin_weak_pullup_enable,
    input wire logic portb_read_pulse,
    output logic [PINS-1:0] pullup_on,
    output logic ext_irq_one_event,
    output logic ext_irq_two_event
);
    // ==========================================================
    // Synchronisers
    logic [2:0] ext_meta;
    logic [2:0] ext_sync;
    logic [2:0] ext_prev;
    logic [PINS-1:0] pb_meta;
    logic [PINS-1:0] pb_sync;
    logic [PINS-1:0] pb_latched;
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ext_meta <= 3'h0;
            ext_sync <= 3'h0;
            ext_prev <= 3'h0;
            pb_meta <= '0;
            pb_sync <= '0;
        end
        else
        begin
            ext_meta <= {ext_irq_two_pin, ext_irq_one_pin, ext_irq_zero_pin};
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            pb_meta <= portb_pins;
            pb_sync <= pb_meta;
        end
    end
    // ==========================================================
    // Registers
    reg_byte_t main_reg;
    reg_byte_t sec_reg;
    logic [4:0] enables;
    logic [2:0] flags;
    logic [2:0] edge_sel;
    logic [2:0] ext_edge;
    logic [PINS-1:0] mismatch;
    logic pb_change;
    logic main_wr;
    logic sec_wr;
    assign edge_sel = {sec_reg[`BIT_EDGE2], sec_reg[`BIT_EDGE1], sec_reg[`BIT_EDGE0]};
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_edge
            // Rising when select is one, falling otherwise
            assign ext_edge[g] = edge_sel[g] ? (ext_sync[g] & ~ext_prev[g])
                                             : (~ext_sync[g] & ext_prev[g]);
        end
        for (g = 0; g < PINS; g++)
        begin : gen_pin
            // Mismatch against last port read, per-pin gated
            assign mismatch[g] = per_pin_change_enable[g] & (pb_sync[g] != pb_latched[g]);
        end
    endgenerate
    assign pb_change = |mismatch;
    // Enables and flags live in separate processes, one writer each
    assign main_reg = {enables, flags};
    assign main_wr = link.reg_req & link.reg_write & (link.reg_sel == `SEL_MAIN);
    assign sec_wr = link.reg_req & link.reg_write & (link.reg_sel == `SEL_SEC);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            pb_latched <= '0;
        else if (portb_read_pulse)
            pb_latched <= pb_sync; // Port read ends mismatch
    end

    // Enable bits plain software storage
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            enables <= 5'(`MAIN_RESET >> 3);
        else if (main_wr)
            enables <= link.reg_wdata[7:3];
    end

    // Sticky flags, hardware set wins over software clear
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flags <= 3'h0;
        else
        begin
            flags[`BIT_TMR0_FLAG] <= timer_overflow_pulse
                | (main_wr ? link.reg_wdata[`BIT_TMR0_FLAG] : flags[`BIT_TMR0_FLAG]);
            flags[`BIT_INT0_FLAG] <= ext_edge[0]
                | (main_wr ? link.reg_wdata[`BIT_INT0_FLAG] : flags[`BIT_INT0_FLAG]);
            flags[`BIT_PB_FLAG] <= pb_change
                | (main_wr ? link.reg_wdata[`BIT_PB_FLAG] : flags[`BIT_PB_FLAG]);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            sec_reg <= `SEC_RESET;
        else if (sec_wr)
            sec_reg <= link.reg_wdata & `SEC_WMASK;
    end
    // ==========================================================
    // Link answers
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            link.reg_ack <= 1'b0;
            link.reg_rdata <= 8'h00;
        end
        else
        begin
            link.reg_ack <= link.reg_req;
            if (link.reg_req && !link.reg_write)
                link.reg_rdata <= (link.reg_sel == `SEL_MAIN) ? main_reg : sec_reg;
        end
    end
    // ==========================================================
    // Interrupt routing
    logic tmr_req;
    logic int0_req;
    logic pb_req;
    logic gie;
    logic pel;
    assign gie = main_reg[`BIT_GLOBAL_HIGH];
    assign pel = main_reg[`BIT_PERIPH_LOW];
    assign tmr_req = main_reg[`BIT_TMR0_EN] & main_reg[`BIT_TMR0_FLAG];
    assign int0_req = main_reg[`BIT_INT0_EN] & main_reg[`BIT_INT0_FLAG];
    assign pb_req = main_reg[`BIT_PB_EN] & main_reg[`BIT_PB_FLAG];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            link.irq_high <= 1'b0;
            link.irq_low <= 1'b0;
        end
        else if (!priority_mode_enable)
        begin
            // Core sources need only bit 7; peripherals need bit 6 too
            link.irq_high <= gie & (tmr_req | int0_req | pb_req | (pel & periph_irq_pending));
            link.irq_low <= 1'b0;
        end
        else
        begin
            // External zero is always high priority
            link.irq_high <= gie & (int0_req | periph_irq_high_pending
                | (tmr_req & sec_reg[`BIT_TMR0_PRIO]) | (pb_req & sec_reg[`BIT_PB_PRIO]));
            // Low priority also needs bit 7 set
            link.irq_low <= gie & pel & (periph_irq_low_pending
                | (tmr_req & ~sec_reg[`BIT_TMR0_PRIO]) | (pb_req & ~sec_reg[`BIT_PB_PRIO]));
        end
    end
    // ==========================================================
    // Pull-ups and other edge outputs
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pullup_on <= '0;
            ext_irq_one_event <= 1'b0;
            ext_irq_two_event <= 1'b0;
        end
        else
        begin
            pullup_on <= {PINS{~sec_reg[`BIT_PULLUP_DIS_N]}} & portb_is_input
                & per_pin_weak_pullup_enable;
            ext_irq_one_event <= ext_edge[1];
            ext_irq_two_event <= ext_edge[2];
        end
    end
endmodule

// >>> hdl/irq_ctrl_cfg.svh
/*
 Bit positions, reset values and encodings of the two interrupt control registers.
 Assumes inclusion by bare name from both end modules and the testbench files.
*/
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
// ==========================================================
// Main control register fields
`define BIT_GLOBAL_HIGH 7
`define BIT_PERIPH_LOW 6
`define BIT_TMR0_EN 5
`define BIT_INT0_EN 4
`define BIT_PB_EN 3
`define BIT_TMR0_FLAG 2
`define BIT_INT0_FLAG 1
`define BIT_PB_FLAG 0
`define MAIN_RESET 8'h00
// ==========================================================
// Secondary control register fields
`define BIT_PULLUP_DIS_N 7
`define BIT_EDGE0 6
`define BIT_EDGE1 5
`define BIT_EDGE2 4
`define BIT_TMR0_PRIO 2
`define BIT_PB_PRIO 0
`define SEC_RESET 8'hF5
`define SEC_WMASK 8'hF5
// ==========================================================
// Register select codes and host register byte addresses
`define SEL_MAIN 1'b0
`define SEL_SEC 1'b1
`define ADDR_CMD 12'h000
`define ADDR_WDATA 12'h004
`define ADDR_RDATA 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_IRQ_STAT 12'h010
`define ADDR_IRQ_MASK 12'h014
`define CMD_GO_BIT 0
`define CMD_WRITE_BIT 1
`define CMD_SEL_BIT 2
`endif

// >>> hdl/irq_ctrl_pkg.sv
/*
 Types shared by the interrupt control ends.
 Assumes the cfg header for numeric constants.
*/
package irq_ctrl_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [2:0] {
        host_idle = 3'b001,
        host_req = 3'b010,
        host_wait = 3'b100
    } host_state_t;
endpackage

// >>> hdl/irq_ctrl_if.sv
/*
 Link between the interrupt control register block and the core-side controller.
 Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
interface irq_ctrl_if;
    logic reg_req;
    logic reg_write;
    logic reg_sel;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    logic irq_high;
    logic irq_low;
    modport device
    (
        input reg_req,
        input reg_write,
        input reg_sel,
        input reg_wdata,
        output reg_rdata,
        output reg_ack,
        output irq_high,
        output irq_low
    );
    modport host
    (
        output reg_req,
        output reg_write,
        output reg_sel,
        output reg_wdata,
        input reg_rdata,
        input reg_ack,
        input irq_high,
        input irq_low
    );
endinterface

// >>> hdl/core_irq_host.sv
/*
 Core-side controller: takes register orders over APB and runs them on the link.
 Assumes the device answers one cycle after each request pulse.
*/
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module core_irq_host
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    irq_ctrl_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    host_state_t state;
    reg_byte_t wdata;
    reg_byte_t rdata;
    logic busy_write;
    logic busy_sel;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic access;
    logic done;
    logic wr;
    logic go;
    logic known;
    assign access = psel & penable & ~pready;
    // Writes land only at the edge that completes the transfer
    assign done = psel & penable & pready;
    assign wr = done & pwrite;
    assign go = wr && paddr == `ADDR_CMD && pwdata[`CMD_GO_BIT] && state == host_idle;
    assign known = paddr == `ADDR_CMD || paddr == `ADDR_WDATA || paddr == `ADDR_RDATA
        || paddr == `ADDR_STATUS || paddr == `ADDR_IRQ_STAT || paddr == `ADDR_IRQ_MASK;
    // ==========================================================
    // Link sequencer
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state <= host_idle;
            link.reg_req <= 1'b0;
            link.reg_write <= 1'b0;
            link.reg_sel <= 1'b0;
            link.reg_wdata <= 8'h00;
            rdata <= 8'h00;
        end
        else
        begin
            link.reg_req <= 1'b0;
            unique case (state)
                host_idle:
                    if (go)
                    begin
                        link.reg_write <= pwdata[`CMD_WRITE_BIT];
                        link.reg_sel <= pwdata[`CMD_SEL_BIT];
                        link.reg_wdata <= wdata;
                        link.reg_req <= 1'b1;
                        state <= host_req;
                    end
                host_req:
                    state <= host_wait;
                host_wait:
                    if (link.reg_ack)
                    begin
                        if (!link.reg_write)
                            rdata <= link.reg_rdata;
                        state <= host_idle;
                    end
            endcase
        end
    end
    // ==========================================================
    // APB slave
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            wdata <= 8'h00;
            irq_mask <= 2'h0;
        end
        else
        begin
            pready <= access;
            pslverr <= access & ~known;
            if (wr && paddr == `ADDR_WDATA)
                wdata <= pwdata[7:0];
            if (wr && paddr == `ADDR_IRQ_MASK)
                irq_mask <= pwdata[1:0];
            if (access && !pwrite)
            begin
                unique case (paddr)
                    `ADDR_WDATA: prdata <= {24'h00_0000, wdata};
                    `ADDR_RDATA: prdata <= {24'h00_0000, rdata};
                    `ADDR_STATUS: prdata <= {29'h0000_0000, link.irq_low, link.irq_high,
                        state != host_idle};
                    `ADDR_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat};
                    `ADDR_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // ==========================================================
    // Interrupt status: bit0 high, bit1 low request; set wins over clear
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= {link.irq_low, link.irq_high}
                | (irq_stat & ~((wr && paddr == `ADDR_IRQ_STAT) ? pwdata[1:0] : 2'h0));
            irq <= |(irq_stat & irq_mask);
        end
    end
endmodule

// >>> testbench/irq_link_sva.sv
/*
 Checker of the link between the two interrupt control ends.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module irq_link_sva
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic irq_high,
    input wire logic irq_low
);
    logic [7:0] main_sh;
    logic [7:0] sec_sh;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Shadows of what was written over the link
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            main_sh <= `MAIN_RESET;
            sec_sh <= `SEC_RESET;
        end
        else if (reg_req && reg_write)
        begin
            if (reg_sel == `SEL_SEC)
                sec_sh <= reg_wdata & `SEC_WMASK;
            else
                main_sh <= reg_wdata;
        end
    end
    // ==========================================================
    // Properties
    sequence rd_main;
        reg_req && !reg_write && reg_sel == `SEL_MAIN;
    endsequence
    sequence rd_sec;
        reg_req && !reg_write && reg_sel == `SEL_SEC;
    endsequence
    a_ack_follows_req: assert property (reg_req |=> reg_ack)
        else $error("link ack missing after request");
    a_ack_needs_req: assert property (reg_ack |-> $past(reg_req))
        else $error("link ack without request");
    a_req_spacing: assert property (reg_req |=> !reg_req [*2])
        else $error("link requests too close");
    a_rdata_holds: assert property (!reg_ack |-> $stable(reg_rdata))
        else $error("link read data moved without ack");
    a_sec_readback: assert property (rd_sec |=> reg_rdata == sec_sh)
        else $error("secondary readback wrong");
    a_main_enables: assert property
        (rd_main |=> reg_rdata[7:3] == main_sh[7:3])
        else $error("main enable readback wrong");
    a_global_blocks: assert property ((!main_sh[7]) [*4] |-> !irq_high && !irq_low)
        else $error("interrupt while global enable clear");
    a_low_gated: assert property ((!main_sh[6]) [*4] |-> !irq_low)
        else $error("low interrupt while bit 6 clear");
endmodule

// >>> testbench/core_interrupt_control_regs_tb_top.sv
/*
 Testbench of the interrupt control pair: APB on the host end, sources on the device end.
 Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module core_interrupt_control_regs_tb_top;
    typedef struct {logic [7:0] v; logic [7:0] m; logic e; string n;} note_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, ev1, ev2;
    logic prio = 1'b0, tmr = 1'b0, rd_pb = 1'b0;
    logic [2:0] pend = 3'h0, ext = 3'h0;
    logic [3:0] pb = 4'h0, pb_in = 4'h0, ioc = 4'hF, wpu = 4'h0, pull;
    logic [23:0] tbl [9] = '{24'h40_F580, 24'h42_F5C0, 24'h91_F5C0, 24'h90_F540,
        24'hA2_F580, 24'h81_F1E4, 24'h81_F4C9, 24'h82_F5C9, 24'h82_F5E4};
    int n_fail = 0, checks = 0, n1 = 0, n2 = 0;
    note_t notes [$];
    irq_ctrl_if bus ();
    core_interrupt_control_regs #(.PINS(4)) core_interrupt_control_regs_i
    (
        .core_clk(core_clk), .reset_n(reset_n), .link(bus.device),
        .priority_mode_enable(prio), .periph_irq_pending(pend[2]),
        .periph_irq_high_pending(pend[1]), .periph_irq_low_pending(pend[0]),
        .timer_overflow_pulse(tmr), .ext_irq_zero_pin(ext[0]), .ext_irq_one_pin(ext[1]),
        .ext_irq_two_pin(ext[2]), .portb_pins(pb), .portb_is_input(pb_in),
        .per_pin_change_enable(ioc), .per_pin_weak_pullup_enable(wpu),
        .portb_read_pulse(rd_pb), .pullup_on(pull), .ext_irq_one_event(ev1),
        .ext_irq_two_event(ev2)
    );
    core_irq_host core_irq_host_i
    (
        .core_clk(core_clk), .reset_n(reset_n), .link(bus.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
    );
    irq_link_sva irq_link_sva_i
    (
        .core_clk(core_clk), .reset_n(reset_n), .reg_req(bus.reg_req),
        .reg_write(bus.reg_write), .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata),
        .reg_rdata(bus.reg_rdata), .reg_ack(bus.reg_ack), .irq_high(bus.irq_high),
        .irq_low(bus.irq_low)
    );
    always #50 core_clk = ~core_clk;
    // ==========================================================
    // Tasks and watchers
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m,
        input string n, output logic [31:0] q);
        notes.push_back('{e, m, a > `ADDR_IRQ_MASK, n});
        apb(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic lnk(input logic w, input logic s, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, `ADDR_WDATA, {24'h00_0000, d}, q);
        apb(1'b1, `ADDR_CMD, {29'h0000_0000, s, w, 1'b1}, q);
        q = 32'h0000_0001;
        for (int i = 0; i < 20 && q[0] === 1'b1; i++)
            rd(`ADDR_STATUS, 8'h00, 8'h00, "status", q);
        // A link that never goes idle counts as a failure
        check("busy", {7'h00, q[0]}, 8'h00);
    endtask
    task automatic reg_rd(input logic s, input logic [7:0] e, input logic [7:0] m,
        input string n);
        logic [31:0] q;
        lnk(1'b0, s, 8'h00);
        rd(`ADDR_RDATA, e, m, n, q);
    endtask
    task automatic fire(input int i);
        tmr <= (i == 0);
        ext[0] <= (i == 1);
        if (i == 2)
            pb <= ~pb;
        cyc(1);
        tmr <= 1'b0;
        cyc(5);
        ext[0] <= 1'b0;
        rd_pb <= 1'b1;
        cyc(1);
        rd_pb <= 1'b0;
        cyc(5);
    endtask
    always @(posedge core_clk)
    begin
        note_t nt;
        if (reset_n)
        begin
            n1 <= n1 + (ev1 === 1'b1);
            n2 <= n2 + (ev2 === 1'b1);
        end
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
        begin
            nt = notes.pop_front();
            check("pslverr", {7'h00, pslverr}, {7'h00, nt.e});
            if (nt.m !== 8'h00)
                check(nt.n, prdata[7:0] & nt.m, nt.v);
        end
    end
    initial
    begin
        #2_000_000;
        n_fail++;
        close_out();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        logic [31:0] q;
        logic [7:0] r;
        int b1, b2;
        void'($urandom(36));
        cyc(12);
        reset_n <= 1'b1;
        cyc(1);
        reg_rd(`SEL_MAIN, 8'h00, 8'hFF, "main");
        reg_rd(`SEL_SEC, 8'hF5, 8'hFF, "sec");
        r = 8'($urandom());
        pb_in <= r[3:0];
        wpu <= r[7:4];
        lnk(1'b1, `SEL_SEC, 8'h75);
        cyc(3);
        check("pullup", {4'h0, pull}, {4'h0, r[3:0] & r[7:4]});
        lnk(1'b1, `SEL_SEC, 8'hFF);
        reg_rd(`SEL_SEC, 8'hF5, 8'hFF, "sec");
        check("pullup", {4'h0, pull}, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            lnk(1'b1, `SEL_SEC, s ? 8'hF5 : 8'h85);
            b1 = n1;
            b2 = n2;
            ext[2:1] <= 2'b11;
            cyc(6);
            check("edges", 8'((n1 - b1) * 16 + n2 - b2), 8'(s * 17));
            ext[2:1] <= 2'b00;
            cyc(6);
            check("edges", 8'((n1 - b1) * 16 + n2 - b2), 8'h11);
        end
        for (int i = 0; i < 3; i++)
            fire(i);
        reg_rd(`SEL_MAIN, 8'h07, 8'hFF, "flags");
        cyc(10);
        reg_rd(`SEL_MAIN, 8'h07, 8'hFF, "flags");
        lnk(1'b1, `SEL_MAIN, 8'h00);
        pb <= ~pb;
        cyc(5);
        lnk(1'b1, `SEL_MAIN, 8'h00);
        reg_rd(`SEL_MAIN, 8'h01, 8'h07, "mismatch");
        rd_pb <= 1'b1;
        cyc(1);
        rd_pb <= 1'b0;
        lnk(1'b1, `SEL_MAIN, 8'h00);
        reg_rd(`SEL_MAIN, 8'h00, 8'h07, "mismatch");
        for (int i = 0; i < 6; i++)
        begin
            lnk(1'b1, `SEL_MAIN, 8'h00);
            lnk(1'b1, `SEL_MAIN, 8'(8'h80 | ((i % 2) << (5 - i / 2))));
            fire(i / 2);
            check("irq_high", {7'h00, bus.irq_high}, 8'(i % 2));
        end
        lnk(1'b1, `SEL_MAIN, 8'h3F);
        cyc(3);
        check("irq_high", {7'h00, bus.irq_high}, 8'h00);
        foreach (tbl[j])
        begin
            {prio, pend} <= tbl[j][23:20];
            lnk(1'b1, `SEL_SEC, tbl[j][15:8]);
            lnk(1'b1, `SEL_MAIN, tbl[j][7:0]);
            cyc(4);
            check("irq_lines", {6'h00, bus.irq_high, bus.irq_low},
                {6'h00, tbl[j][17:16]});
        end
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0000, q);
        cyc(3);
        check("irq", {7'h00, irq}, 8'h00);
        rd(`ADDR_IRQ_STAT, 8'h01, 8'h01, "irq_stat", q);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0001, q);
        cyc(3);
        check("irq", {7'h00, irq}, 8'h01);
        lnk(1'b1, `SEL_MAIN, 8'h00);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h0000_0003, q);
        cyc(3);
        check("irq", {7'h00, irq}, 8'h00);
        rd(`ADDR_IRQ_STAT, 8'h00, 8'h01, "irq_stat", q);
        rd(12'hFFC, 8'h00, 8'h00, "unmapped", q);
        close_out();
    end
endmodule
